// ===== rtl/event_transfer_engine.sv
// module: channel controller with queues and four transfer controllers
`timescale 1ns/1ps
module event_transfer_engine #(
  parameter int NUM_SETS = dma_pkg::N_SETS,
  parameter int QDEPTH = dma_pkg::Q_DEPTH
) (
  input wire logic clk,
  input wire logic srst,
  // one fixed event line per channel
  input wire logic [dma_pkg::N_EVT-1:0] hw_event,
  input wire logic [dma_pkg::N_EVT-1:0] sw_event_set,
  input wire logic [dma_pkg::N_EVT-1:0] event_enable_register,
  // descriptor memory write port
  input wire logic desc_wr,
  input wire logic [$clog2(NUM_SETS)-1:0] desc_set,
  input wire logic [2:0] desc_word,
  input wire logic [31:0] desc_wdata,
  // quick channel map write
  input wire logic qmap_wr,
  input wire logic [2:0] qmap_ch,
  input wire logic [$clog2(NUM_SETS)-1:0] qmap_set,
  input wire logic [2:0] qmap_trig,
  input wire logic [dma_pkg::N_QUEUES-1:0][dma_pkg::PRIO_W-1:0] queue_prio,
  input wire logic [dma_pkg::N_QUEUES-1:0] err_clear,
  // transfer controller memory ports
  output logic [dma_pkg::N_QUEUES-1:0] rd_req,
  output logic [dma_pkg::N_QUEUES-1:0][31:0] rd_addr,
  input wire logic [dma_pkg::N_QUEUES-1:0][63:0] rd_data,
  input wire logic [dma_pkg::N_QUEUES-1:0] rd_valid,
  output logic [dma_pkg::N_QUEUES-1:0] wr_req,
  output logic [dma_pkg::N_QUEUES-1:0][31:0] wr_addr,
  output logic [dma_pkg::N_QUEUES-1:0][63:0] wr_data,
  input wire logic [dma_pkg::N_QUEUES-1:0] wr_ack,
  output logic [dma_pkg::N_QUEUES-1:0][dma_pkg::PRIO_W-1:0] tc_prio_q,
  // status
  output logic [dma_pkg::N_EVT-1:0] event_latch_register_q,
  output logic done_irq_q,
  output logic [6:0] done_chan_q,
  output logic err_irq_q,
  output logic [dma_pkg::N_QUEUES-1:0] err_queue_q
);
  import dma_pkg::*;
  localparam int SW = $clog2(NUM_SETS);

  ////////////////////////////////////////////////////////////////////
  // types and storage

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ISSUE = 3'b010,
    ST_LINK = 3'b100
  } cc_st_e;
  cc_st_e st_q; // dispatcher state

  logic [31:0] desc_q [NUM_SETS][SET_WORDS]; // descriptor_memory
  logic [N_EVT-1:0] evt_prev_q; // last sampled event lines
  logic [N_QCH-1:0] qpend_q; // quick channels triggered
  logic [SW-1:0] qch_set_q [N_QCH]; // quick channel to set map
  logic [2:0] qch_trig_q [N_QCH]; // trigger word per quick channel
  logic [SW-1:0] cur_set_q; // set being serviced
  logic [6:0] cur_ch_q; // channel being serviced, bit 6 = quick

  // lowest set bit of a vector, used for events and quick channels
  function automatic logic [5:0] pick_low(input logic [N_EVT-1:0] v);
    logic [5:0] r;
    r = '0;
    for (int i = N_EVT - 1; i >= 0; i--) begin
      if (v[i]) r = 6'(i);
    end
    return r;
  endfunction : pick_low

  ////////////////////////////////////////////////////////////////////
  // event intake

  wire logic [N_EVT-1:0] evt_rise = hw_event & ~evt_prev_q;
  // disabled channels latch but are not dispatched
  wire logic [N_EVT-1:0] evt_pend =
    event_latch_register_q & event_enable_register;
  wire logic evt_any = |evt_pend;
  wire logic q_any = |qpend_q;
  wire logic [5:0] pick_evt = pick_low(evt_pend);
  // a call result cannot be sliced directly, so widen and cut in two steps
  wire logic [5:0] pick_q_w = pick_low(N_EVT'(qpend_q));
  wire logic [2:0] pick_q = pick_q_w[2:0];
  wire logic is_quick = cur_ch_q[6];

  ////////////////////////////////////////////////////////////////////
  // descriptor decode for the set in service

  wire logic [31:0] opt_w = desc_q[cur_set_q][W_OPT];
  wire logic [31:0] src_w = desc_q[cur_set_q][W_SRC];
  wire logic [31:0] cnt_w = desc_q[cur_set_q][W_CNT];
  wire logic [31:0] dst_w = desc_q[cur_set_q][W_DST];
  wire logic [31:0] bidx_w = desc_q[cur_set_q][W_BIDX];
  wire logic [31:0] link_w = desc_q[cur_set_q][W_LINK];
  wire logic [31:0] cidx_w = desc_q[cur_set_q][W_CIDX];
  wire logic [15:0] ccnt_w = desc_q[cur_set_q][W_CCNT][15:0];
  wire logic [15:0] bcnt_w = cnt_w[31:16];
  wire logic sync2d = opt_w[O_SYNC2D];
  wire logic [1:0] q_sel = opt_w[O_QUE+:2];
  wire logic [SW-1:0] link_set = link_w[SW-1:0];
  wire logic link_ok = (link_w[15:0] != LINK_NULL);
  wire logic [31:0] link_src_w = desc_q[link_set][W_SRC];

  // two-dim mode always closes a frame; one-dim only on its last array
  wire logic last_arr = sync2d || (bcnt_w <= CNT_ONE);
  wire logic exhaust = last_arr && (ccnt_w <= CNT_ONE);
  // address step per dimension, source and destination apart
  wire logic [31:0] src_nx = src_w + sext(last_arr ? cidx_w[15:0] :
    bidx_w[15:0]);
  wire logic [31:0] dst_nx = dst_w + sext(last_arr ? cidx_w[31:16] :
    bidx_w[31:16]);
  wire logic [15:0] bcnt_nx = sync2d ? bcnt_w :
    (last_arr ? link_w[31:16] : bcnt_w - CNT_ONE);
  wire logic [15:0] ccnt_nx = last_arr ? ccnt_w - CNT_ONE : ccnt_w;
  // self chain keeps the channel armed until all dims are done
  wire logic rearm = !exhaust && opt_w[O_SELF];

  ////////////////////////////////////////////////////////////////////
  // request build and queue hand-off

  tr_s tr_w;
  always_comb begin
    tr_w = '0;
    tr_w.src = src_w;
    tr_w.dst = dst_w;
    tr_w.acnt = cnt_w[15:0];
    tr_w.bcnt = sync2d ? bcnt_w : CNT_ONE;
    tr_w.sbidx = bidx_w[15:0];
    tr_w.dbidx = bidx_w[31:16];
    tr_w.sconst = opt_w[O_SCONST];
    tr_w.dconst = opt_w[O_DCONST];
    tr_w.final_tr = exhaust;
    tr_w.irq_en = opt_w[O_IRQ];
    tr_w.chain_en = opt_w[O_CHAIN];
    tr_w.chain_tgt = opt_w[O_TGT+:6];
    tr_w.chan = cur_ch_q;
  end

  logic [N_QUEUES-1:0] q_ready; // room in each event queue
  logic [N_QUEUES-1:0] tc_done; // final request finished
  tr_s tc_tr [N_QUEUES]; // request that finished
  wire logic in_issue = (st_q == ST_ISSUE);
  wire logic q_rdy_sel = q_ready[q_sel];
  wire logic push = in_issue && q_rdy_sel;

  tr_if qin [N_QUEUES] ();
  tr_if qout [N_QUEUES] ();

  // four queues, each feeding its own transfer controller
  for (genvar g = 0; g < N_QUEUES; g++) begin : g_q
    assign qin[g].valid = in_issue && (q_sel == 2'(g));
    assign qin[g].data = tr_w;
    assign q_ready[g] = qin[g].ready;
    tr_queue #(.DEPTH(QDEPTH)) u_q (.clk(clk), .srst(srst),
      .in_q(qin[g]), .out_q(qout[g]));
    transfer_controller u_tc (
      .clk(clk),
      .srst(srst),
      .req(qout[g]),
      .rd_req_q(rd_req[g]),
      .rd_addr_q(rd_addr[g]),
      .rd_data(rd_data[g]),
      .rd_valid(rd_valid[g]),
      .wr_req_q(wr_req[g]),
      .wr_addr_q(wr_addr[g]),
      .wr_data_q(wr_data[g]),
      .wr_ack(wr_ack[g]),
      .done_q(tc_done[g]),
      .done_tr_q(tc_tr[g])
    );
  end

  ////////////////////////////////////////////////////////////////////
  // completion fan-in: chain targets and interrupt choice

  logic [N_EVT-1:0] chain_set; // channels retriggered by chaining
  logic any_irq; // a finished request asks for an interrupt
  logic [6:0] irq_chan; // lowest queue wins when several finish
  always_comb begin
    chain_set = '0;
    any_irq = 1'b0;
    irq_chan = '0;
    for (int k = N_QUEUES - 1; k >= 0; k--) begin
      if (tc_done[k] && tc_tr[k].chain_en) begin
        chain_set[tc_tr[k].chain_tgt] = 1'b1;
      end
      if (tc_done[k] && tc_tr[k].irq_en) begin
        any_irq = 1'b1;
        irq_chan = tc_tr[k].chan;
      end
    end
  end

  // latch clear only when the request really left
  wire logic [N_EVT-1:0] evt_clr = (push && !is_quick && !rearm) ?
    (N_EVT'(1) << cur_ch_q[5:0]) : '0;
  wire logic [N_QCH-1:0] q_clr = (push && is_quick && !rearm) ?
    (N_QCH'(1) << cur_ch_q[2:0]) : '0;
  logic [N_QCH-1:0] q_hit; // trigger word of a quick channel written
  always_comb begin
    for (int q = 0; q < N_QCH; q++) begin
      q_hit[q] = desc_wr && (desc_set == qch_set_q[q]) &&
        (desc_word == qch_trig_q[q]);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // event latch, quick pending, error and status flags; set wins

  always_ff @(posedge clk) begin
    if (srst) begin
      evt_prev_q <= '0;
      event_latch_register_q <= '0;
      qpend_q <= '0;
      err_queue_q <= '0;
      err_irq_q <= 1'b0;
      done_irq_q <= 1'b0;
      done_chan_q <= '0;
      tc_prio_q <= '0;
    end else begin
      evt_prev_q <= hw_event;
      event_latch_register_q <= (event_latch_register_q & ~evt_clr) |
        evt_rise | sw_event_set | chain_set;
      qpend_q <= (qpend_q & ~q_clr) | q_hit;
      // full queue: flag it, leave the event latched
      err_irq_q <= in_issue && !q_rdy_sel;
      err_queue_q <= (err_queue_q & ~err_clear) |
        ((in_issue && !q_rdy_sel) ? (N_QUEUES'(1) << q_sel) : '0);
      done_irq_q <= any_irq;
      if (any_irq) done_chan_q <= irq_chan;
      tc_prio_q <= queue_prio;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // quick channel map

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int q = 0; q < N_QCH; q++) begin
        qch_set_q[q] <= SW'(N_EVT + q);
        qch_trig_q[q] <= W_CCNT;
      end
    end else if (qmap_wr) begin
      qch_set_q[qmap_ch] <= qmap_set;
      qch_trig_q[qmap_ch] <= qmap_trig;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // dispatcher: event channels before quick ones, lowest index first

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= ST_IDLE;
      cur_set_q <= '0;
      cur_ch_q <= '0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          if (evt_any) begin
            cur_ch_q <= {1'b0, pick_evt};
            cur_set_q <= SW'(pick_evt);
            st_q <= ST_ISSUE;
          end else if (q_any) begin
            cur_ch_q <= {4'h8, pick_q};
            cur_set_q <= qch_set_q[pick_q];
            st_q <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          // on a full queue fall back and retry later
          st_q <= (push && exhaust && link_ok) ? ST_LINK : ST_IDLE;
        end
        ST_LINK: st_q <= ST_IDLE;
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // descriptor memory; dispatcher updates follow software writes

  always_ff @(posedge clk) begin
    if (desc_wr) desc_q[desc_set][desc_word] <= desc_wdata;
    if (push) begin
      desc_q[cur_set_q][W_SRC] <= src_nx;
      desc_q[cur_set_q][W_DST] <= dst_nx;
      desc_q[cur_set_q][W_CNT] <= {bcnt_nx, cnt_w[15:0]};
      desc_q[cur_set_q][W_CCNT] <= {16'h0, ccnt_nx};
    end
    if (st_q == ST_LINK) begin
      for (int k = 0; k < SET_WORDS; k++) begin
        desc_q[cur_set_q][k] <= desc_q[link_set][k];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks

  a_hw_latch: assert property (@(posedge clk) disable iff (srst)
    (|evt_rise) |=> ((event_latch_register_q & $past(evt_rise)) ==
      $past(evt_rise))) else $error("hardware event not latched");
  a_sw_latch: assert property (@(posedge clk) disable iff (srst)
    (|sw_event_set) |=> ((event_latch_register_q & $past(sw_event_set))
      == $past(sw_event_set))) else $error("software set lost");
  a_chain_target: assert property (@(posedge clk) disable iff (srst)
    (|chain_set) |=> ((event_latch_register_q & $past(chain_set)) ==
      $past(chain_set))) else $error("chain target not triggered");
  a_quick_trig: assert property (@(posedge clk) disable iff (srst)
    (|q_hit) |=> ((qpend_q & $past(q_hit)) == $past(q_hit)))
    else $error("quick trigger lost");
  a_one_array: assert property (@(posedge clk) disable iff (srst)
    (push && !sync2d && bcnt_w > CNT_ONE && !desc_wr) |=>
      (bcnt_w == $past(bcnt_w) - CNT_ONE) && (ccnt_w == $past(ccnt_w)))
    else $error("one-dim step wrong");
  a_full_frame: assert property (@(posedge clk) disable iff (srst)
    (push && sync2d && ccnt_w > CNT_ONE && !desc_wr) |=>
      (ccnt_w == $past(ccnt_w) - CNT_ONE) && (bcnt_w == $past(bcnt_w)))
    else $error("two-dim frame step wrong");
  a_overflow_err: assert property (@(posedge clk) disable iff (srst)
    (in_issue && !q_rdy_sel) |=> err_irq_q && err_queue_q[$past(q_sel)] &&
      (st_q == ST_IDLE)) else $error("overflow not flagged");
  a_link_reload: assert property (@(posedge clk) disable iff (srst)
    (st_q == ST_LINK && !desc_wr) |=> (src_w == $past(link_src_w)))
    else $error("link reload missing");
endmodule : event_transfer_engine

// ===== rtl/dma_pkg.sv
// package: constants, descriptor layout and request type of the dma engine
// Notes on behaviour
// - 64 event channels plus 8 quick channels
// - one-dim mode: one array per event
// - two-dim mode: one whole frame per event
// - self-chain runs full 3-D from one event
// - separate source and destination index per dimension
// - each pointer incrementing or constant
// - exhausted descriptor reloads from its link set
// - completion and error interrupts, status kept
// - software set bit acts as hardware event
// - completion triggers the chain target channel
// - quick channel fires on trigger word write
// - quick channel to set mapping is programmable
// - 256 descriptor sets, any use
// - each set is eight 32-bit words
// - four queues, priority set by software
// - each queue holds sixteen entries
// - transfer controllers use 64-bit data ports
// - at most four requests in flight per controller
// - controllers do two dims, third done upstream
// - event to channel mapping is fixed
// - events latch even while channel disabled
package dma_pkg;
  localparam int N_EVT = 64;
  localparam int N_QCH = 8;
  localparam int N_SETS = 256;
  localparam int SET_WORDS = 8;
  localparam int N_QUEUES = 4;
  localparam int Q_DEPTH = 16;
  localparam int TC_INFLIGHT = 4;
  localparam int PRIO_W = 3;
  // word index inside one descriptor set
  localparam logic [2:0] W_OPT = 3'h0;
  localparam logic [2:0] W_SRC = 3'h1;
  localparam logic [2:0] W_CNT = 3'h2;
  localparam logic [2:0] W_DST = 3'h3;
  localparam logic [2:0] W_BIDX = 3'h4;
  localparam logic [2:0] W_LINK = 3'h5;
  localparam logic [2:0] W_CIDX = 3'h6;
  localparam logic [2:0] W_CCNT = 3'h7;
  // option word field positions
  localparam int O_SYNC2D = 0;
  localparam int O_SCONST = 1;
  localparam int O_DCONST = 2;
  localparam int O_IRQ = 3;
  localparam int O_CHAIN = 4;
  localparam int O_SELF = 5;
  localparam int O_TGT = 8;
  localparam int O_QUE = 16;
  localparam logic [15:0] LINK_NULL = 16'hffff;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [31:0] BEAT_INC = 32'h0000_0008;
  // one two-dimensional request as handed to a transfer controller
  typedef struct packed {
    logic [31:0] src;
    logic [31:0] dst;
    logic [15:0] acnt;
    logic [15:0] bcnt;
    logic [15:0] sbidx;
    logic [15:0] dbidx;
    logic sconst;
    logic dconst;
    logic final_tr;
    logic irq_en;
    logic chain_en;
    logic [5:0] chain_tgt;
    logic [6:0] chan;
  } tr_s;
  // signed 16-bit index widened to an address step
  function automatic logic [31:0] sext(input logic [15:0] v);
    return {{16{v[15]}}, v};
  endfunction : sext
endpackage : dma_pkg

// ===== rtl/tr_if.sv
// interface: valid/ready carrier of transfer requests
`timescale 1ns/1ps
interface tr_if;
  import dma_pkg::*;
  tr_s data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport dst (input data, input valid, output ready);
endinterface : tr_if

// ===== rtl/tr_queue.sv
// module: first-in first-out queue of transfer requests
`timescale 1ns/1ps
module tr_queue #(
  parameter int DEPTH = dma_pkg::Q_DEPTH
) (
  input wire logic clk,
  input wire logic srst,
  tr_if.dst in_q,
  tr_if.src out_q
);
  import dma_pkg::*;
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
  tr_s mem [DEPTH]; // storage, no reset needed
  logic [AW-1:0] wp_q; // write index
  logic [AW-1:0] rp_q; // read index
  logic [AW:0] cnt_q; // entries held
  wire logic push = in_q.valid && in_q.ready;
  wire logic pop = out_q.valid && out_q.ready;
  assign in_q.ready = (cnt_q != FULL);
  assign out_q.valid = (cnt_q != '0);
  assign out_q.data = mem[rp_q];
  ////////////////////////////////////////////////////////////////////
  // pointers move in one direction only, so order is kept
  always_ff @(posedge clk) begin
    if (srst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
  // data storage
  always_ff @(posedge clk) begin
    if (push) mem[wp_q] <= in_q.data;
  end
  a_count_bound: assert property (@(posedge clk) disable iff (srst)
    (cnt_q == FULL) |-> !in_q.ready) else $error("queue over depth");
endmodule : tr_queue

// ===== rtl/transfer_controller.sv
// module: two-dimensional transfer controller with 64-bit ports
`timescale 1ns/1ps
module transfer_controller (
  input wire logic clk,
  input wire logic srst,
  tr_if.dst req,
  output logic rd_req_q,
  output logic [31:0] rd_addr_q,
  input wire logic [63:0] rd_data,
  input wire logic rd_valid,
  output logic wr_req_q,
  output logic [31:0] wr_addr_q,
  output logic [63:0] wr_data_q,
  input wire logic wr_ack,
  output logic done_q,
  output dma_pkg::tr_s done_tr_q
);
  import dma_pkg::*;
  typedef enum logic [2:0] {
    T_IDLE = 3'b001,
    T_RD = 3'b010,
    T_WR = 3'b100
  } tc_st_e;
  tc_st_e st_q;
  tr_if fl ();
  tr_s cur; // head of the in-flight buffer is the active request
  logic [31:0] src_q, dst_q, asrc_q, adst_q;
  logic [15:0] a_left_q, b_left_q;
  // requests wait here; the buffer depth caps what is in flight
  tr_queue #(.DEPTH(TC_INFLIGHT)) u_fl (.clk(clk), .srst(srst),
    .in_q(req), .out_q(fl));
  assign cur = fl.data;
  wire logic last_a = (a_left_q <= CNT_ONE);
  wire logic last_b = (b_left_q <= CNT_ONE);
  wire logic beat_done = (st_q == T_WR) && wr_ack;
  wire logic [31:0] nsrc = cur.sconst ? src_q : src_q + BEAT_INC;
  wire logic [31:0] ndst = cur.dconst ? dst_q : dst_q + BEAT_INC;
  wire logic [31:0] bsrc = asrc_q + sext(cur.sbidx);
  wire logic [31:0] bdst = adst_q + sext(cur.dbidx);
  assign fl.ready = beat_done && last_a && last_b;
  ////////////////////////////////////////////////////////////////////
  // read one beat, write it, step through arrays and the frame
  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= T_IDLE;
      rd_req_q <= 1'b0;
      wr_req_q <= 1'b0;
      done_q <= 1'b0;
      {src_q, dst_q, asrc_q, adst_q} <= '0;
      {a_left_q, b_left_q, rd_addr_q, wr_addr_q, wr_data_q} <= '0;
      done_tr_q <= '0;
    end else begin
      done_q <= 1'b0;
      unique case (st_q)
        T_IDLE: if (fl.valid) begin
          src_q <= cur.src;
          dst_q <= cur.dst;
          asrc_q <= cur.src;
          adst_q <= cur.dst;
          a_left_q <= cur.acnt;
          b_left_q <= cur.bcnt;
          rd_addr_q <= cur.src;
          rd_req_q <= 1'b1;
          st_q <= T_RD;
        end
        T_RD: if (rd_valid) begin
          rd_req_q <= 1'b0;
          wr_data_q <= rd_data;
          wr_addr_q <= dst_q;
          wr_req_q <= 1'b1;
          st_q <= T_WR;
        end
        T_WR: if (wr_ack) begin
          wr_req_q <= 1'b0;
          if (last_a && last_b) begin // frame complete
            done_q <= cur.final_tr;
            done_tr_q <= cur;
            st_q <= T_IDLE;
          end else begin
            st_q <= T_RD;
            rd_req_q <= 1'b1;
            if (last_a) begin // next array
              a_left_q <= cur.acnt;
              b_left_q <= b_left_q - CNT_ONE;
              asrc_q <= bsrc;
              adst_q <= bdst;
              src_q <= bsrc;
              dst_q <= bdst;
              rd_addr_q <= bsrc;
            end else begin
              a_left_q <= a_left_q - CNT_ONE;
              src_q <= nsrc;
              dst_q <= ndst;
              rd_addr_q <= nsrc;
            end
          end
        end
        default: st_q <= T_IDLE;
      endcase
    end
  end
  a_rd_to_wr: assert property (@(posedge clk) disable iff (srst)
    (st_q == T_RD && rd_valid) |=> wr_req_q && (wr_data_q == $past(rd_data)))
    else $error("read beat not written");
  a_const_src: assert property (@(posedge clk) disable iff (srst)
    (beat_done && !last_a && cur.sconst) |=> (src_q == $past(src_q)))
    else $error("constant source moved");
endmodule : transfer_controller

// ===== bench/mem_model.sv
// partner model: memory behind the four transfer controller ports
`timescale 1ns/1ps
module mem_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic slow,
  input wire logic [3:0] rd_req,
  input wire logic [3:0][31:0] rd_addr,
  output logic [3:0][63:0] rd_data,
  output logic [3:0] rd_valid,
  input wire logic [3:0] wr_req,
  output logic [3:0] wr_ack
);
  logic tick_q; // gates answers to every other cycle when slow
  ////////////////////////////////////////////////////////////////////////
  // one pulse per held request; idle data is scrambled, never stale
  always_ff @(posedge clk) begin
    tick_q <= srst ? 1'b0 : ~tick_q;
    for (int i = 0; i < 4; i++) begin
      rd_valid[i] <= ~srst & rd_req[i] & ~rd_valid[i] & (~slow | tick_q);
      wr_ack[i] <= ~srst & wr_req[i] & ~wr_ack[i] & (~slow | tick_q);
      // read data is the address and its inverse
      if (rd_req[i] & ~rd_valid[i] & (~slow | tick_q))
        rd_data[i] <= {rd_addr[i], ~rd_addr[i]};
      else
        rd_data[i] <= ~rd_data[i];
    end
  end
endmodule : mem_model

// ===== bench/tb_event_transfer_engine.sv
// testbench: event and quick channel transfers through queue 0
`timescale 1ns/1ps
module tb_event_transfer_engine;
  import dma_pkg::*;
  logic clk = 0, srst = 1, slow = 0;
  logic [63:0] hw_event = '0, sw_event_set = '0;
  logic [63:0] event_enable_register = '0, event_latch_register_q;
  logic desc_wr = 0, qmap_wr = 0, done_irq_q, err_irq_q;
  logic [7:0] desc_set = '0, qmap_set = '0;
  logic [2:0] desc_word = '0, qmap_ch = '0, qmap_trig = '0;
  logic [31:0] desc_wdata = '0;
  logic [3:0][2:0] queue_prio = '0, tc_prio_q;
  logic [3:0] err_clear = '0, rd_req, rd_valid, wr_req, wr_ack, err_queue_q;
  logic [3:0][31:0] rd_addr, wr_addr;
  logic [3:0][63:0] rd_data, wr_data;
  logic [6:0] done_chan_q, last_ch;
  logic [95:0] wq[$]; // finished write beats of lane 0
  int n_fail = 0, compares = 0, n_irq = 0, n_err = 0;
  always #10 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  event_transfer_engine event_transfer_engine_i (.clk, .srst, .hw_event,
    .sw_event_set, .event_enable_register, .desc_wr, .desc_set, .desc_word,
    .desc_wdata, .qmap_wr, .qmap_ch, .qmap_set, .qmap_trig, .queue_prio,
    .err_clear, .rd_req, .rd_addr, .rd_data, .rd_valid, .wr_req, .wr_addr,
    .wr_data, .wr_ack, .tc_prio_q, .event_latch_register_q, .done_irq_q,
    .done_chan_q, .err_irq_q, .err_queue_q);
  mem_model mem_model_i (.clk, .srst, .slow, .rd_req, .rd_addr, .rd_data,
    .rd_valid, .wr_req, .wr_ack);
  ////////////////////////////////////////////////////////////////////////
  // log write handshakes and completion pulses as they happen
  always @(posedge clk) begin
    if (wr_req[0] && wr_ack[0])
      wq.push_back({wr_addr[0], wr_data[0]});
    if (done_irq_q === 1'b1) begin
      n_irq++;
      last_ch = done_chan_q;
    end
    if (err_irq_q === 1'b1) n_err++;
  end
  task automatic chk(input string what, input logic [95:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  // write all eight words; the last one is the quick trigger word
  task automatic put_set(input logic [7:0] s, input logic [31:0] w[8]);
    for (int k = 0; k < 8; k++) begin
      @(negedge clk);
      desc_wr = 1;
      desc_set = s;
      desc_word = k[2:0];
      desc_wdata = w[k];
    end
    @(negedge clk);
    desc_wr = 0;
  endtask : put_set
  // bounded wait for n beats plus a completion, then walk the addresses
  task automatic beats(input int n, input logic [31:0] s0, d0, ds,
    input logic [6:0] ch);
    logic [31:0] s;
    for (int t = 0; t < 600 && (wq.size() < n || n_irq == 0); t++)
      @(negedge clk);
    if (wq.size() < n || n_irq == 0) begin
      n_fail++;
      test_done();
    end
    for (int k = 0; k < n; k++) begin
      s = s0 + 32'(k) * BEAT_INC;
      chk("beat", wq[k], {d0 + 32'(k) * ds, s, ~s});
    end
    chk("count", 96'(wq.size()), 96'(n));
    chk("irq chan", 96'(last_ch), 96'(ch));
    wq.delete();
    n_irq = 0;
  endtask : beats
  // manual start of channel 5 via the software set bits
  task automatic t_manual;
    event_enable_register[5] = 1;
    put_set(8'h05, '{32'h8, 32'h1000, 32'h0001_0002, 32'h2000, 32'h0,
      32'h0001_ffff, 32'h0, 32'h1});
    sw_event_set[5] = 1;
    @(negedge clk);
    sw_event_set[5] = 0;
    beats(2, 32'h1000, 32'h2000, BEAT_INC, 7'h05);
    $display("t_manual finished");
  endtask : t_manual
  // event on a disabled channel waits latched; constant destination
  task automatic t_latch;
    put_set(8'h03, '{32'hc, 32'h3000, 32'h0001_0002, 32'h4000, 32'h0,
      32'h0001_ffff, 32'h0, 32'h1});
    hw_event[3] = 1;
    repeat (4) @(negedge clk);
    chk("latched", 96'(event_latch_register_q), 96'h8);
    chk("held", 96'(wq.size()), 96'h0);
    event_enable_register[3] = 1;
    hw_event[3] = 0;
    beats(2, 32'h3000, 32'h4000, 32'h0, 7'h03);
    chk("cleared", 96'(event_latch_register_q[3]), 96'h0);
    $display("t_latch finished");
  endtask : t_latch
  // two-dim self chain: two frames from one event, then link and chain
  task automatic t_chain;
    logic [31:0] es, ed;
    put_set(8'h50, '{32'h0, 32'hb000, 32'h0001_0001, 32'hc000, 32'h0,
      32'h0001_ffff, 32'h0, 32'h1});
    put_set(8'h06, '{32'h739, 32'h9000, 32'h0002_0001, 32'ha000,
      32'h0020_0010, 32'h0001_0050, 32'h0200_0100, 32'h2});
    event_enable_register[6] = 1;
    sw_event_set[6] = 1;
    @(negedge clk);
    sw_event_set[6] = 0;
    for (int t = 0; t < 600 && n_irq == 0; t++)
      @(negedge clk);
    if (n_irq == 0 || wq.size() != 4) begin
      n_fail++;
      test_done();
    end
    for (int k = 0; k < 4; k++) begin
      es = 32'h9000 + 32'(k / 2) * 32'h100 + 32'(k % 2) * 32'h10;
      ed = 32'ha000 + 32'(k / 2) * 32'h200 + 32'(k % 2) * 32'h20;
      chk("src", 96'(wq[k][63:32]), 96'(es));
      chk("dst", 96'(wq[k][95:64]), 96'(ed));
    end
    chk("irq chan", 96'(last_ch), 96'h6);
    chk("chained", 96'(event_latch_register_q[7]), 96'h1);
    wq.delete();
    n_irq = 0;
    $display("t_chain finished");
  endtask : t_chain
  // quick channel 2 remapped to set 0x64, slow memory answers
  task automatic t_quick;
    slow = 1;
    qmap_wr = 1;
    qmap_ch = 3'h2;
    qmap_set = 8'h64;
    qmap_trig = 3'h7;
    @(negedge clk);
    qmap_wr = 0;
    put_set(8'h64, '{32'h8, 32'h5000, 32'h0001_0002, 32'h6000, 32'h0,
      32'h0001_ffff, 32'h0, 32'h1});
    beats(2, 32'h5000, 32'h6000, BEAT_INC, 7'h42);
    $display("t_quick finished");
  endtask : t_quick
  // 32 channels at once overrun queue 0; no event is lost
  task automatic t_flood;
    queue_prio = {3'h1, 3'h2, 3'h3, 3'h4};
    for (int c = 8; c < 40; c++)
      put_set(8'(c), '{32'h0, 32'h7000, 32'h0001_0002, 32'h8000, 32'h0,
        32'h0001_ffff, 32'h0, 32'h1});
    chk("prio", 96'(tc_prio_q), 96'h29c);
    event_enable_register[39:8] = '1;
    sw_event_set[39:8] = '1;
    @(negedge clk);
    sw_event_set = '0;
    for (int t = 0; t < 3000 && wq.size() < 64; t++)
      @(negedge clk);
    if (wq.size() < 64) begin
      n_fail++;
      test_done();
    end
    repeat (20) @(negedge clk);
    chk("beats", 96'(wq.size()), 96'd64);
    chk("overflow", 96'(n_err > 0), 96'h1);
    chk("err flag", 96'(err_queue_q), 96'h1);
    err_clear = 4'h1;
    @(negedge clk);
    err_clear = '0;
    chk("err clear", 96'(err_queue_q), 96'h0);
    wq.delete();
    $display("t_flood finished");
  endtask : t_flood
  ////////////////////////////////////////////////////////////////////////
  // reset for 16 cycles, then the scenarios in turn
  initial begin
    repeat (16) @(negedge clk);
    srst = 0;
    t_manual();
    t_latch();
    t_chain();
    t_quick();
    t_flood();
    test_done();
  end
endmodule : tb_event_transfer_engine
